// [hw/sdd_dma_regs.v]
// Purpose: DMA completion interrupt, transfer size and checksum report registers
// Assumes: Local and host byte ports on core_clk; one-cycle read/write strobes
// Notes: Read data is registered, valid the cycle after the strobe
//        Busy pins pass a three-stage synchroniser before they are shown
//        Payload windows only hand bytes over; the engine keeps the data
//
// Notes on behaviour
// - Four completion enables in upper nibble
// - Four pending flags in low nibble
// - Local read clears pending; host read doesn't
// - Enables local read/write, host read only
// - Host reads/writes sixteen-bit inbound size bytes
// - Outbound size bytes host read-only
// - Host access of bad register records failure
// - Host access of good register records success
// - Sizes and checksum registers reset zero
// - Busy flag per channel, zero idle
// - Payload windows: host writes in, reads out
`timescale 1ns/1ns
`include "sdd_map.vh"
module sdd_dma_regs #(
    parameter ADDR_W = 9,
    parameter NCH = 4
) (
    input wire core_clk,
    input wire rst_n,
    // Local processor port
    input wire loc_rd,
    input wire loc_wr,
    input wire [ADDR_W-1:0] loc_addr,
    input wire [7:0] loc_wdata,
    output wire [7:0] loc_rdata,
    // SDIO host port, function 1
    input wire host_rd,
    input wire host_wr,
    input wire [ADDR_W-1:0] host_addr,
    input wire [7:0] host_wdata,
    output wire [7:0] host_rdata,
    // DMA engine side: busy levels from pins, completion pulses on core_clk
    input wire [NCH-1:0] chan_busy_pin,
    input wire [NCH-1:0] chan_done,
    input wire [15:0] out_size,
    input wire out_size_load,
    input wire [7:0] out_payload,
    output wire [7:0] in_payload,
    output wire in_payload_valid,
    output wire out_payload_taken,
    output wire [15:0] in_size,
    output wire [1:0] crc_report,
    output wire dma_irq
);
    // ****************************************
    // Storage
    // ****************************************
    reg [NCH-1:0] irq_en_reg; // Completion enables, written by the local side only
    reg [NCH-1:0] pend_reg; // Completion pending flags
    reg [NCH-1:0] pend_next; // Pending flags after this cycle
    reg [15:0] in_size_reg; // Host-written inbound size
    reg [15:0] out_size_reg; // Device-loaded outbound size
    reg [1:0] crc_reg; // Latest outbound checksum verdict
    reg [7:0] loc_rdata_reg; // Local read data, held until the next local read
    reg [7:0] host_rdata_reg; // Host read data, held until the next host read
    reg [7:0] in_payload_reg; // Last inbound payload byte
    reg in_payload_valid_reg; // One-cycle mark of a fresh inbound byte
    wire [NCH-1:0] busy_sync; // Synchronised busy levels
    wire [7:0] status_byte; // Busy flags as the status register shows them
    // Address decodes, one per register access that has an effect
    wire loc_irq_rd; // Local read of the interrupt register
    wire loc_irq_wr; // Local write of the interrupt register
    wire host_size_lo_wr; // Host write of the inbound size low byte
    wire host_size_hi_wr; // Host write of the inbound size high byte
    wire host_any; // Host read or write strobe
    wire host_bad_hit; // Host access to the bad-checksum report
    wire host_good_hit; // Host access to the good-checksum report
    wire host_win_wr; // Host write of the inbound payload window
    wire host_win_rd; // Host read of the outbound payload window

    // One synchroniser per busy pin
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : g_busy
            sdd_sync u_sync (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .raw_pin(chan_busy_pin[g]),
                .clean_level(busy_sync[g])
            );
        end
    endgenerate

    // ****************************************
    // Address decode
    // ****************************************
    // Host writes to the interrupt register decode to nothing: enables are local-only
    assign loc_irq_rd = loc_rd && (loc_addr == `SDD_OFF_DMA_IRQ);
    assign loc_irq_wr = loc_wr && (loc_addr == `SDD_OFF_DMA_IRQ);
    assign host_size_lo_wr = host_wr && (host_addr == `SDD_OFF_IN_SIZE_LO);
    assign host_size_hi_wr = host_wr && (host_addr == `SDD_OFF_IN_SIZE_HI);
    assign host_any = host_rd || host_wr;
    // A read counts as much as a write: the access itself is the message
    assign host_bad_hit = host_any && (host_addr == `SDD_OFF_CRC_BAD);
    assign host_good_hit = host_any && (host_addr == `SDD_OFF_CRC_GOOD);
    assign host_win_wr = host_wr && (host_addr == `SDD_OFF_IN_WINDOW);
    assign host_win_rd = host_rd && (host_addr == `SDD_OFF_OUT_WINDOW);

    // ****************************************
    // Outputs
    // ****************************************
    assign in_size = in_size_reg;
    assign crc_report = crc_reg;
    assign loc_rdata = loc_rdata_reg;
    assign host_rdata = host_rdata_reg;
    assign in_payload = in_payload_reg;
    assign in_payload_valid = in_payload_valid_reg;
    // Status register: outbound busy in bits 7:6, inbound busy in bits 5:4
    // The busy port keeps the pending bit order, so the two halves swap here
    assign status_byte = {busy_sync[1:0], busy_sync[3:2], `SDD_RST_NIBBLE};
    // Handshake pulse: host pulled one outbound byte
    assign out_payload_taken = host_win_rd;

    // ****************************************
    // Pending flags: set beats clear
    // ****************************************
    always @* begin
        pend_next = pend_reg;
        if (loc_irq_rd) begin
            // The read already returned the old flags, so all may go
            pend_next = `SDD_RST_NIBBLE;
        end
        // New completion in the clearing cycle is kept
        pend_next = pend_next | chan_done;
    end

    // ****************************************
    // Register updates
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_en_reg <= `SDD_RST_NIBBLE;
            pend_reg <= `SDD_RST_NIBBLE;
            in_size_reg <= {`SDD_RST_BYTE, `SDD_RST_BYTE};
            out_size_reg <= {`SDD_RST_BYTE, `SDD_RST_BYTE};
            crc_reg <= `SDD_CRC_NONE;
            in_payload_reg <= `SDD_RST_BYTE;
            in_payload_valid_reg <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            // Valid is a pulse unless a window write renews it below
            in_payload_valid_reg <= 1'b0;
            // Only the local side may change enables
            if (loc_irq_wr) begin
                irq_en_reg <= loc_wdata[`SDD_IRQ_EN_MSB:`SDD_IRQ_EN_LSB];
            end
            // Inbound size bytes belong to the host; each byte lands alone
            if (host_size_lo_wr) begin
                in_size_reg[7:0] <= host_wdata;
            end
            if (host_size_hi_wr) begin
                in_size_reg[15:8] <= host_wdata;
            end
            // Outbound size only from the engine; host writes never land
            if (out_size_load) begin
                out_size_reg <= out_size;
            end
            // Any host access to a report register records its verdict
            if (host_bad_hit) begin
                crc_reg <= `SDD_CRC_BAD;
            end else if (host_good_hit) begin
                crc_reg <= `SDD_CRC_GOOD;
            end
            // Inbound payload byte handed to the engine as one pulse
            if (host_win_wr) begin
                in_payload_reg <= host_wdata;
                in_payload_valid_reg <= 1'b1;
            end
        end
    end

    // ****************************************
    // Local read data
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loc_rdata_reg <= `SDD_RST_BYTE;
        end else if (loc_rd) begin
            case (loc_addr)
                `SDD_OFF_DMA_IRQ: loc_rdata_reg <= {irq_en_reg, pend_reg};
                `SDD_OFF_DMA_STATUS: loc_rdata_reg <= status_byte;
                // Sizes, windows and reports have no local access
                default: loc_rdata_reg <= `SDD_RST_BYTE;
            endcase
        end
    end

    // ****************************************
    // Host read data; host reads never clear flags
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_reg <= `SDD_RST_BYTE;
        end else if (host_rd) begin
            case (host_addr)
                `SDD_OFF_DMA_IRQ: host_rdata_reg <= {irq_en_reg, pend_reg};
                `SDD_OFF_DMA_STATUS: host_rdata_reg <= status_byte;
                // Inbound size reads back what the host wrote
                `SDD_OFF_IN_SIZE_LO: host_rdata_reg <= in_size_reg[7:0];
                `SDD_OFF_IN_SIZE_HI: host_rdata_reg <= in_size_reg[15:8];
                `SDD_OFF_OUT_SIZE_LO: host_rdata_reg <= out_size_reg[7:0];
                `SDD_OFF_OUT_SIZE_HI: host_rdata_reg <= out_size_reg[15:8];
                `SDD_OFF_OUT_WINDOW: host_rdata_reg <= out_payload;
                // Report registers always read zero
                `SDD_OFF_CRC_BAD: host_rdata_reg <= `SDD_RST_BYTE;
                `SDD_OFF_CRC_GOOD: host_rdata_reg <= `SDD_RST_BYTE;
                default: host_rdata_reg <= `SDD_RST_BYTE;
            endcase
        end
    end

    // ****************************************
    // Local interrupt request
    // ****************************************
    // Combinational request: any enabled pending channel
    // Both inputs are flip-flops, so the level cannot glitch on a strobe
    // Disabling a channel hides its flag but leaves it pending
    assign dma_irq = |(pend_reg & irq_en_reg);
endmodule

// [hw/sdd_map.vh]
// Purpose: Offsets, field positions and reset values of the DMA control block
// Assumes: Byte-wide registers at function-1 byte offsets
// Notes: Definitions only
`ifndef SDD_MAP_VH
`define SDD_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define SDD_ADDR_W 9
`define SDD_OFF_DMA_STATUS 9'h108
`define SDD_OFF_IN_WINDOW 9'h10C
`define SDD_OFF_OUT_WINDOW 9'h110
`define SDD_OFF_DMA_IRQ 9'h168
`define SDD_OFF_IN_SIZE_LO 9'h198
`define SDD_OFF_IN_SIZE_HI 9'h19C
`define SDD_OFF_OUT_SIZE_LO 9'h1A0
`define SDD_OFF_OUT_SIZE_HI 9'h1A4
`define SDD_OFF_CRC_BAD 9'h1A8
`define SDD_OFF_CRC_GOOD 9'h1AC
// ****************************************
// Field positions and resets
// ****************************************
`define SDD_IRQ_EN_MSB 7
`define SDD_IRQ_EN_LSB 4
`define SDD_IRQ_PEND_MSB 3
`define SDD_IRQ_PEND_LSB 0
`define SDD_BUSY_MSB 7
`define SDD_BUSY_LSB 4
`define SDD_RST_BYTE 8'h00
`define SDD_RST_NIBBLE 4'h0
// Checksum report codes
`define SDD_CRC_NONE 2'h0
`define SDD_CRC_BAD 2'h1
`define SDD_CRC_GOOD 2'h2
`endif

// [hw/sdd_sync.v]
// Purpose: Three-stage synchroniser with agreement filter for one pin level
// Assumes: Input is asynchronous to core_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module sdd_sync (
    input wire core_clk,
    input wire rst_n,
    input wire raw_pin,
    output wire clean_level
);
    // Synchroniser stages
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg level_reg; // Accepted level, moves only on agreement
    assign clean_level = level_reg;
    // ****************************************
    // Shift stages, update when 2nd and 3rd agree
    // ****************************************
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= raw_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // Agreement filters a single-cycle glitch
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end
endmodule

// [tb/sdd_dma_regs_asserts.sv]
// Purpose: Port-level checks of the DMA control register block
// Assumes: One clock; rst_n asynchronous, active low
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
`include "sdd_map.vh"
module sdd_dma_regs_asserts (
    input wire core_clk,
    input wire rst_n,
    input wire loc_rd,
    input wire loc_wr,
    input wire [8:0] loc_addr,
    input wire [7:0] loc_rdata,
    input wire host_rd,
    input wire host_wr,
    input wire [8:0] host_addr,
    input wire [7:0] host_wdata,
    input wire [3:0] chan_done,
    input wire out_payload_taken,
    input wire [15:0] in_size,
    input wire [1:0] crc_report,
    input wire dma_irq
);
    // ****************************************
    // Checks on core_clk
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Quiet reads: no completion pulse could re-arm a flag meanwhile
    wire l_rd = loc_rd && loc_addr == `SDD_OFF_DMA_IRQ && chan_done == 4'h0;
    wire h_rd = host_rd && host_addr == `SDD_OFF_DMA_IRQ && !loc_rd && !loc_wr
        && chan_done == 4'h0;
    chk_two_reads: assert property (l_rd ##1 l_rd |=> loc_rdata[3:0] == 4'h0)
        else $error("pending kept over a local read");
    chk_read_drops_irq: assert property (l_rd |=> !dma_irq)
        else $error("interrupt kept after local read");
    chk_host_keeps: assert property (h_rd |=> dma_irq == $past(dma_irq))
        else $error("host read changed interrupt");
    chk_bad_report: assert property ((host_rd || host_wr) &&
        host_addr == `SDD_OFF_CRC_BAD |=> crc_report == `SDD_CRC_BAD)
        else $error("bad report missed");
    chk_good_report: assert property ((host_rd || host_wr) &&
        host_addr == `SDD_OFF_CRC_GOOD |=> crc_report == `SDD_CRC_GOOD)
        else $error("good report missed");
    chk_window_take: assert property (out_payload_taken ==
        (host_rd && host_addr == `SDD_OFF_OUT_WINDOW))
        else $error("window read not taken");
    chk_size_write: assert property (host_wr && host_addr == `SDD_OFF_IN_SIZE_LO
        |=> in_size[7:0] == $past(host_wdata))
        else $error("size low byte not written");
    chk_reset_zero: assert property ($rose(rst_n) |-> in_size == 16'h0000 && crc_report == 2'h0)
        else $error("size or report not zero after reset");
endmodule
bind sdd_dma_regs sdd_dma_regs_asserts u_chk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .loc_rd(loc_rd),
    .loc_wr(loc_wr),
    .loc_addr(loc_addr),
    .loc_rdata(loc_rdata),
    .host_rd(host_rd),
    .host_wr(host_wr),
    .host_addr(host_addr),
    .host_wdata(host_wdata),
    .chan_done(chan_done),
    .out_payload_taken(out_payload_taken),
    .in_size(in_size),
    .crc_report(crc_report),
    .dma_irq(dma_irq)
);

// [tb/sdd_eng_model.sv]
// Purpose: Behavioural DMA engine on the far side of the register block
// Assumes: Driven at the falling edge of core_clk
// Notes: Payload byte is a fixed level
`timescale 1ns/1ns
module sdd_eng_model (
    input wire core_clk,
    output reg [3:0] chan_busy_pin,
    output reg [3:0] chan_done,
    output reg [15:0] out_size,
    output reg out_size_load,
    output reg [7:0] out_payload
);
    initial {chan_busy_pin, chan_done, out_size, out_size_load, out_payload} = {25'h0, 8'hA5};
    // Start a transfer: busy pin up, size loaded for one cycle
    task start(input [1:0] ch, input [15:0] sz);
        @(negedge core_clk);
        chan_busy_pin[ch] = 1'b1;
        {out_size, out_size_load} = {sz, 1'b1};
        @(negedge core_clk);
        out_size_load = 1'b0;
    endtask
    // End a transfer: busy pin down, one completion pulse
    task finish(input [1:0] ch);
        @(negedge core_clk);
        chan_busy_pin[ch] = 1'b0;
        chan_done[ch] = 1'b1;
        @(negedge core_clk);
        chan_done = 4'h0;
    endtask
endmodule

// [tb/sdd_dma_regs_test.sv]
// Purpose: Register-level tests of the DMA control block
// Assumes: Inputs change at the falling edge of core_clk
// Notes: Strobe held n cycles gives back-to-back accesses
`timescale 1ns/1ns
`include "sdd_map.vh"
module sdd_dma_regs_test;
    localparam [8:0] IRQ = `SDD_OFF_DMA_IRQ;
    localparam [71:0] ZMAP = {9'h000, 9'h108, 9'h168, 9'h198, 9'h19C, 9'h1A0, 9'h1A4, 9'h1AC};
    reg core_clk = 1'b0, rst_n = 1'b0, loc_rd = 1'b0, loc_wr = 1'b0, host_rd = 1'b0, host_wr = 1'b0;
    reg [8:0] loc_addr = 9'h000, host_addr = 9'h000;
    reg [7:0] loc_wdata = 8'h00, host_wdata = 8'h00, e;
    wire [7:0] loc_rdata, host_rdata, out_payload, in_payload;
    wire [3:0] chan_busy_pin, chan_done;
    wire [15:0] out_size, in_size;
    wire out_size_load, in_payload_valid, out_payload_taken, dma_irq;
    wire [1:0] crc_report;
    integer err_count = 0, comparisons = 0, i;
    always #5 core_clk = ~core_clk;
    sdd_eng_model u_eng (
        .core_clk(core_clk),
        .chan_busy_pin(chan_busy_pin),
        .chan_done(chan_done),
        .out_size(out_size),
        .out_size_load(out_size_load),
        .out_payload(out_payload)
    );
    sdd_dma_regs u_dut (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .loc_rd(loc_rd),
        .loc_wr(loc_wr),
        .loc_addr(loc_addr),
        .loc_wdata(loc_wdata),
        .loc_rdata(loc_rdata),
        .host_rd(host_rd),
        .host_wr(host_wr),
        .host_addr(host_addr),
        .host_wdata(host_wdata),
        .host_rdata(host_rdata),
        .chan_busy_pin(chan_busy_pin),
        .chan_done(chan_done),
        .out_size(out_size),
        .out_size_load(out_size_load),
        .out_payload(out_payload),
        .in_payload(in_payload),
        .in_payload_valid(in_payload_valid),
        .out_payload_taken(out_payload_taken),
        .in_size(in_size),
        .crc_report(crc_report),
        .dma_irq(dma_irq)
    );
    // Compare and count
    task check(input [15:0] seen, input [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    // One access on the host (h) or local port
    task acc(input h, input w, input [8:0] a, input [7:0] d, input integer n);
        @(negedge core_clk);
        if (h) {host_rd, host_wr, host_addr, host_wdata} = {!w, w, a, d};
        else {loc_rd, loc_wr, loc_addr, loc_wdata} = {!w, w, a, d};
        repeat (n) @(negedge core_clk);
        {loc_rd, loc_wr, host_rd, host_wr} = 4'h0;
    endtask
    task rd(input h, input [8:0] a, input [7:0] exp, input integer n);
        acc(h, 1'b0, a, 8'h00, n);
        check(h ? host_rdata : loc_rdata, exp);
    endtask
    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog: the tests need under two thousand ns
    initial begin
        #100000;
        err_count = err_count + 1;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        for (i = 0; i < 8; i = i + 1)
            rd(1'b1, ZMAP[i*9 +: 9], 8'h00, 1);
        rd(1'b0, IRQ, 8'h00, 1);
        $display("test reset done");
        acc(1'b0, 1'b1, IRQ, 8'h5F, 1);
        rd(1'b0, IRQ, 8'h50, 1);
        acc(1'b1, 1'b1, IRQ, 8'hFF, 1);
        rd(1'b1, IRQ, 8'h50, 1);
        u_eng.finish(2'd1);
        check(dma_irq, 1'b0);
        rd(1'b0, IRQ, 8'h52, 1);
        acc(1'b0, 1'b1, IRQ, 8'hF0, 1);
        $display("test enables done");
        for (i = 0; i < 4; i = i + 1) begin
            e = 8'hF0 | (8'h01 << i);
            u_eng.start(i[1:0], {i[7:0], 8'hC3 ^ i[7:0]});
            repeat (6) @(negedge core_clk);
            // Status shows outbound busy in bits 7:6, inbound in bits 5:4
            rd(1'b1, 9'h108, 8'h10 << ((i + 2) % 4), 1);
            rd(1'b0, 9'h108, 8'h10 << ((i + 2) % 4), 1);
            acc(1'b1, 1'b1, 9'h1A0, 8'hFF, 1);
            rd(1'b1, 9'h1A0, 8'hC3 ^ i[7:0], 1);
            rd(1'b1, 9'h1A4, i[7:0], 1);
            u_eng.finish(i[1:0]);
            check(dma_irq, 1'b1);
            rd(1'b1, IRQ, e, 1);
            rd(1'b0, IRQ, e, 1);
            rd(1'b0, IRQ, 8'hF0, 2);
            check(dma_irq, 1'b0);
        end
        $display("test completion done");
        acc(1'b1, 1'b1, 9'h198, 8'h34, 1);
        acc(1'b1, 1'b1, 9'h19C, 8'hFF, 1);
        check(in_size, 16'hFF34);
        rd(1'b1, 9'h19C, 8'hFF, 1);
        rd(1'b0, 9'h198, 8'h00, 1);
        rd(1'b1, 9'h1A8, 8'h00, 1);
        check(crc_report, `SDD_CRC_BAD);
        acc(1'b1, 1'b1, 9'h1AC, 8'h00, 1);
        check(crc_report, `SDD_CRC_GOOD);
        acc(1'b1, 1'b1, 9'h10C, 8'h6B, 1);
        check({in_payload_valid, in_payload}, 9'h16B);
        rd(1'b1, 9'h110, 8'hA5, 1);
        // Take pulse stands only while the window read is on the bus
        @(negedge core_clk) {host_rd, host_addr} = {1'b1, 9'h110};
        #2 check(out_payload_taken, 1'b1);
        @(negedge core_clk) host_rd = 1'b0;
        #2 check(out_payload_taken, 1'b0);
        $display("test sizes and windows done");
        tally_and_finish;
    end
endmodule
